// ===== design/iwc_top.sv
`timescale 1ns/1ps
module iwc_top
   import iwc_pkg::*;
#(
   parameter int PORT_W = PORT_W_DEF,
   parameter int STAB_W = STAB_W_DEF,
   parameter logic [STAB_W_DEF-1:0] STAB_CYCLES = STAB_CYCLES_DEF[STAB_W_DEF-1:0]
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic nmi_pin_n,
   input wire logic src1_pin_n,
   input wire logic [PORT_W-1:0] port_irq_n,
   input wire logic spi_eot,
   input wire logic timer_zero_flag,
   input wire logic timer_irq_enable,
   input wire logic adc_eoc,
   input wire logic adc_irq_enable,
   input wire logic wdg_active,
   input wire logic [1:0] core_mode,
   input wire logic instr_end,
   input wire logic wait_exec,
   input wire logic stop_exec,
   output logic irq_take,
   output logic [2:0] irq_src,
   output logic core_halt,
   output logic osc_stop,
   output logic stab_busy,
   output logic core_resume
);
   iwc_src_if nmi_if ();
   iwc_src_if s1_if ();
   iwc_src_if s2_if ();

   logic [7:0] opt_ff;
   logic wr_opt_ff;
   logic [31:0] rd_data_ff;
   iwc_state_t st_ff;
   iwc_state_t nxt_st;
   logic [STAB_W-1:0] stab_cnt_ff;
   logic [STAB_W-1:0] nxt_stab_cnt;
   logic irq_take_ff;
   logic [2:0] irq_src_ff;
   logic resume_ff;
   logic [2:0] take_sel;

   // bus decode
   wire acc = hsel & htrans[1] & hready;
   wire adr_opt = (haddr == OPT_ADDR);
   wire adr_stat = (haddr == STAT_ADDR);
   wire word_acc = (hsize == HSIZE_WORD);
   // narrow writes stand for bit ops and are dropped
   wire nxt_wr_opt = acc & hwrite & adr_opt & word_acc;
   wire [7:0] opt_wr_val = hwdata[7:0] & OPT_USED_MASK;

   // option fields
   wire src1_level_edge_select = opt_ff[LES_BIT];
   wire src2_edge_polarity = opt_ff[ESB_BIT];
   wire gen = opt_ff[GEN_BIT];

   // source lines
   wire port_all_hi = &port_irq_n;
   wire timer_req = timer_zero_flag & timer_irq_enable;
   wire adc_req = adc_eoc & adc_irq_enable;

   assign nmi_if.pin_n = nmi_pin_n;
   assign nmi_if.local_evt = 1'b0;
   assign nmi_if.level_mode = 1'b0;
   assign nmi_if.rise_sel = 1'b0;

   assign s1_if.pin_n = src1_pin_n;
   assign s1_if.local_evt = spi_eot;
   assign s1_if.level_mode = src1_level_edge_select;
   assign s1_if.rise_sel = 1'b0;

   // one synchroniser for the whole port, pins are ored low
   assign s2_if.pin_n = port_all_hi;
   assign s2_if.local_evt = 1'b0;
   assign s2_if.level_mode = 1'b0;
   assign s2_if.rise_sel = src2_edge_polarity;

   iwc_src_detect u_nmi (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .src(nmi_if.det)
   );
   iwc_src_detect u_src1 (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .src(s1_if.det)
   );
   iwc_src_detect u_src2 (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .src(s2_if.det)
   );

   wire [4:0] req = {adc_req, timer_req, s2_if.req, s1_if.req, nmi_if.req};

   // acceptance
   wire in_normal = (core_mode == MODE_NORMAL);
   wire in_nmi = (core_mode == MODE_NMI);
   // maskables cannot nest, the NMI cannot re-enter itself
   wire mask_ok = gen & in_normal;
   wire nmi_ok = req[0] & ~in_nmi;
   wire mask_any = mask_ok & (|req[4:1]);
   wire pend_take = nmi_ok | mask_any;

   always_comb begin
      take_sel = SRC_NMI;
      if (nmi_ok) begin
         take_sel = SRC_NMI;
      end else if (req[1]) begin
         take_sel = SRC_1;
      end else if (req[2]) begin
         take_sel = SRC_2;
      end else if (req[3]) begin
         take_sel = SRC_3;
      end else begin
         take_sel = SRC_4;
      end
   end

   // wake conditions
   wire any_req = |req;
   wire ext_req = req[0] | req[1] | req[2];
   // any line wakes from wait, only nmi, source 1 and source 2 wake from stop, regardless of mode, but only with gen set
   wire wake_wait = gen & any_req;
   wire wake_stop = gen & ext_req;
   wire stab_last = (stab_cnt_ff == {{(STAB_W-1){1'b0}}, 1'b1});

   wire in_run = (st_ff == ST_RUN);
   wire sleep_cmd = in_run & (wait_exec | stop_exec);
   wire sleep_go = sleep_cmd & ~pend_take;
   wire stop_ok = stop_exec & ~wdg_active;

   wire resume_wait = (st_ff == ST_WAIT) & wake_wait;
   wire resume_stab = (st_ff == ST_STAB) & stab_last;
   wire resume_ev = resume_wait | resume_stab;

   // after wake the same gating picks service or plain continue
   wire take_pt = (in_run & instr_end) | resume_ev;
   wire take_now = pend_take & take_pt;

   assign nmi_if.clr = take_now & (take_sel == SRC_NMI);
   assign s1_if.clr = take_now & (take_sel == SRC_1);
   assign s2_if.clr = take_now & (take_sel == SRC_2);

   // sleep sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_stab_cnt = stab_cnt_ff;
      case (st_ff)
         ST_RUN: begin
            if (sleep_go && stop_ok) begin
               nxt_st = ST_STOP;
            end else if (sleep_go) begin
               nxt_st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wake_wait) begin
               nxt_st = ST_RUN;
            end
         end
         ST_STOP: begin
            if (wake_stop) begin
               nxt_st = ST_STAB;
               nxt_stab_cnt = STAB_CYCLES;
            end
         end
         ST_STAB: begin
            if (stab_last) begin
               nxt_st = ST_RUN;
            end else begin
               nxt_stab_cnt = stab_cnt_ff - {{(STAB_W-1){1'b0}}, 1'b1};
            end
         end
         default: begin
            nxt_st = ST_RUN;
         end
      endcase
   end

   // status word
   wire [31:0] status_word = {24'h00_0000, req, (st_ff == ST_STAB), (st_ff == ST_STOP),
      ~in_run};
   // option reads as zero, it is write-only
   wire [31:0] nxt_rd = (acc & ~hwrite & adr_stat) ? status_word : 32'h0000_0000;

   // bus and option register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_ff <= OPT_RESET;
         wr_opt_ff <= 1'b0;
         rd_data_ff <= 32'h0000_0000;
      end else begin
         wr_opt_ff <= nxt_wr_opt;
         rd_data_ff <= nxt_rd;
         if (wr_opt_ff) begin
            opt_ff <= opt_wr_val;
         end
      end
   end

   // async reset returns any sleep state straight to run
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RUN;
         stab_cnt_ff <= {STAB_W{1'b0}};
      end else begin
         st_ff <= nxt_st;
         stab_cnt_ff <= nxt_stab_cnt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_ff <= 1'b0;
         irq_src_ff <= SRC_NMI;
         resume_ff <= 1'b0;
      end else begin
         irq_take_ff <= take_now;
         resume_ff <= resume_ev;
         if (take_now) begin
            irq_src_ff <= take_sel;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_data_ff;
   assign irq_take = irq_take_ff;
   assign irq_src = irq_src_ff;
   assign core_halt = ~in_run;
   // only gates the clock, the source choice lives elsewhere
   assign osc_stop = (st_ff == ST_STOP);
   assign stab_busy = (st_ff == ST_STAB);
   assign core_resume = resume_ff;
endmodule

// ===== common/iwc_pkg.sv
package iwc_pkg;
   localparam logic [31:0] OPT_ADDR = 32'h0000_00c8;
   localparam logic [31:0] STAT_ADDR = 32'h0000_0000;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam int LES_BIT = 6;
   localparam int ESB_BIT = 5;
   localparam int GEN_BIT = 4;
   localparam logic [7:0] OPT_USED_MASK = 8'h70;
   localparam int ST_HALT_BIT = 0;
   localparam int ST_OSC_BIT = 1;
   localparam int ST_STAB_BIT = 2;
   localparam int ST_REQ_LSB = 3;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_IRQ = 2'h1;
   localparam logic [1:0] MODE_NMI = 2'h2;
   localparam logic [2:0] SRC_NMI = 3'h0;
   localparam logic [2:0] SRC_1 = 3'h1;
   localparam logic [2:0] SRC_2 = 3'h2;
   localparam logic [2:0] SRC_3 = 3'h3;
   localparam logic [2:0] SRC_4 = 3'h4;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int STAB_CYCLES_DEF = 4096;
   localparam int STAB_W_DEF = 16;
   localparam int PORT_W_DEF = 8;
   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_STAB} iwc_state_t;
endpackage

// ===== common/iwc_src_if.sv
`timescale 1ns/1ps
interface iwc_src_if;
   logic pin_n;
   logic local_evt;
   logic level_mode;
   logic rise_sel;
   logic clr;
   logic req;
   modport det (
      input pin_n,
      input local_evt,
      input level_mode,
      input rise_sel,
      input clr,
      output req
   );
   modport ctl (
      output pin_n,
      output local_evt,
      output level_mode,
      output rise_sel,
      output clr,
      input req
   );
endinterface

// ===== design/iwc_src_detect.sv
`timescale 1ns/1ps
module iwc_src_detect
   import iwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   iwc_src_if.det src
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic filt_ff;
   logic prev_hi_ff;
   logic req_ff;
   wire agree = (s2_ff == s3_ff);
   wire nxt_filt = agree ? s2_ff : filt_ff;
   // same-domain event joins after the filter, it needs no sync
   wire line_hi = filt_ff & ~src.local_evt;
   wire rise_ev = line_hi & ~prev_hi_ff;
   wire fall_ev = ~line_hi & prev_hi_ff;
   wire edge_ev = src.rise_sel ? rise_ev : fall_ev;
   // set beats clear so an edge on the service cycle is kept
   wire nxt_req = edge_ev | (req_ff & ~src.clr);
   assign src.req = src.level_mode ? ~line_hi : req_ff;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         filt_ff <= 1'b1;
         prev_hi_ff <= 1'b1;
         req_ff <= 1'b0;
      end else begin
         s1_ff <= src.pin_n;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         filt_ff <= nxt_filt;
         prev_hi_ff <= line_hi;
         req_ff <= nxt_req;
      end
   end
endmodule

// ===== tb/iwc_top_props.sv
`timescale 1ns/1ps
module iwc_top_props
   import iwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic wdg_active,
   input wire logic stop_exec,
   input wire logic [1:0] core_mode,
   input wire logic irq_take,
   input wire logic [2:0] irq_src,
   input wire logic core_halt,
   input wire logic osc_stop,
   input wire logic stab_busy,
   input wire logic core_resume
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_opt_noread: assert property (hsel && hready && htrans[1] && !hwrite && haddr == OPT_ADDR
      |=> hrdata == 32'h0) else $error("option register read back");
   a_take_pulse: assert property (irq_take |=> !irq_take)
      else $error("take longer than one cycle");
   a_nmi_nobreak: assert property (irq_take |-> $past(core_mode) != MODE_NMI)
      else $error("take inside nmi routine");
   a_irq_only_nmi: assert property (irq_take && $past(core_mode) == MODE_IRQ |-> irq_src == SRC_NMI)
      else $error("maskable nested in routine");
   a_stop_halts: assert property (osc_stop |-> core_halt)
      else $error("oscillator off while running");
   a_wdg_wait: assert property (wdg_active && stop_exec && !core_halt |=> !osc_stop)
      else $error("stop with watchdog active");
   a_wait_nostab: assert property (core_halt && !osc_stop && !stab_busy |=> !stab_busy)
      else $error("delay after wait");
   a_stop_stab: assert property (osc_stop ##1 !osc_stop |-> stab_busy)
      else $error("no delay after stop");
   a_wake_resume: assert property ($fell(core_halt) |-> core_resume)
      else $error("halt dropped without resume");
   c_stab: cover property (stab_busy);
   c_nmi: cover property (irq_take && irq_src == SRC_NMI);
   c_resume: cover property (core_resume);
endmodule
bind iwc_top iwc_top_props u_props (.*);

// ===== tb/iwc_core_model.sv
`timescale 1ns/1ps
module iwc_core_model
   import iwc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic irq_take,
   input wire logic [2:0] irq_src,
   input wire logic core_halt,
   input wire logic ret,
   output logic instr_end,
   output logic [1:0] core_mode
);
   logic [1:0] cnt_ff;
   logic [1:0] mode_ff;
   // an instruction ends every fourth cycle, none while halted
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 2'h0;
         mode_ff <= MODE_NORMAL;
      end else begin
         cnt_ff <= core_halt ? 2'h0 : cnt_ff + 2'h1;
         if (irq_take) begin
            mode_ff <= (irq_src == SRC_NMI) ? MODE_NMI : MODE_IRQ;
         end else if (ret) begin
            mode_ff <= MODE_NORMAL;
         end
      end
   end
   assign instr_end = (cnt_ff == 2'h3) && !core_halt;
   assign core_mode = mode_ff;
endmodule

// ===== tb/iwc_top_tb.sv
`timescale 1ns/1ps
module iwc_top_tb;
   import iwc_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, ret = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0, core_mode;
   logic [2:0] hsize = HSIZE_WORD, irq_src;
   logic [7:0] port_irq_n = 8'hff;
   logic nmi_pin_n = 1'b1, src1_pin_n = 1'b1, spi_eot = 1'b0, wdg_active = 1'b0;
   logic timer_zero_flag = 1'b0, timer_irq_enable = 1'b0, adc_eoc = 1'b0, adc_irq_enable = 1'b0;
   logic wait_exec = 1'b0, stop_exec = 1'b0, instr_end, hreadyout, hresp;
   logic irq_take, core_halt, osc_stop, stab_busy, core_resume;
   wire logic hready;
   wire logic [3:0] mon;
   int n_mismatch = 0, n_checks = 0, n_take = 0, t;
   assign hready = hreadyout;
   assign mon = {stab_busy, osc_stop, core_halt, irq_take};
   iwc_top #(.STAB_CYCLES(16'h0004)) u_dut (.*);
   iwc_core_model u_core (.*);
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (irq_take === 1'b1) n_take++;
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task fail;
      n_mismatch++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test;
   endtask
   task wt(input int k, input logic e);
      for (int i = 0; i < 300 && mon[k] !== e; i++) @(posedge ref_clk);
      if (mon[k] !== e) fail;
   endtask
   task rdy;
      @(posedge ref_clk);
      for (int i = 0; i < 50 && hready !== 1'b1; i++) @(posedge ref_clk);
      if (hready !== 1'b1) fail;
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= a;
      rdy;
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      rdy;
      q = hrdata;
   endtask
   task tk(input logic [2:0] s);
      // step past a take pulse that a previous call has just seen
      @(posedge ref_clk);
      wt(0, 1'b1);
      chk(irq_src, s);
   endtask
   task pulse_ret;
      ret <= 1'b1;
      @(posedge ref_clk) ret <= 1'b0;
   endtask
   task s_reg;
      bus(1'b0, OPT_ADDR, 32'h0); chk(q, 32'h0);
      bus(1'b0, STAT_ADDR, 32'h0); chk(q, 32'h0);
      // level mode with enable low: spare bits set must not enable anything
      bus(1'b1, OPT_ADDR, 32'hcf); t = n_take; spi_eot <= 1'b1;
      repeat (30) @(posedge ref_clk);
      chk(n_take, t);
      bus(1'b1, OPT_ADDR, 32'h50); tk(SRC_1);
      spi_eot <= 1'b0; pulse_ret;
   endtask
   task s_tmr;
      bus(1'b1, OPT_ADDR, 32'h10); t = n_take; timer_zero_flag <= 1'b1;
      repeat (30) @(posedge ref_clk);
      chk(n_take, t);
      timer_irq_enable <= 1'b1; tk(SRC_3);
      nmi_pin_n <= 1'b0; tk(SRC_NMI);
      nmi_pin_n <= 1'b1; timer_zero_flag <= 1'b0; pulse_ret;
   endtask
   task s_edge;
      bus(1'b1, OPT_ADDR, 32'h30); t = n_take; port_irq_n[0] <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk(n_take, t);
      port_irq_n[0] <= 1'b1; tk(SRC_2); pulse_ret;
   endtask
   task s_wait;
      bus(1'b1, OPT_ADDR, 32'h10); wait_exec <= 1'b1;
      @(posedge ref_clk) wait_exec <= 1'b0;
      wt(1, 1'b1); chk(osc_stop, 1'b0);
      adc_irq_enable <= 1'b1; adc_eoc <= 1'b1; tk(SRC_4);
      chk(core_halt, 1'b0); adc_eoc <= 1'b0; pulse_ret;
   endtask
   task s_stop;
      stop_exec <= 1'b1;
      @(posedge ref_clk) stop_exec <= 1'b0;
      wt(2, 1'b1); src1_pin_n <= 1'b0;
      wt(3, 1'b1); chk(osc_stop, 1'b0); tk(SRC_1);
      src1_pin_n <= 1'b1; pulse_ret; wdg_active <= 1'b1; stop_exec <= 1'b1;
      @(posedge ref_clk) stop_exec <= 1'b0;
      wt(1, 1'b1); chk(osc_stop, 1'b0); nmi_pin_n <= 1'b0; tk(SRC_NMI);
      nmi_pin_n <= 1'b1; wdg_active <= 1'b0; pulse_ret;
   endtask
   task s_gen0;
      bus(1'b1, OPT_ADDR, 32'h0); wait_exec <= 1'b1;
      @(posedge ref_clk) wait_exec <= 1'b0;
      wt(1, 1'b1); t = n_take; nmi_pin_n <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk(core_halt, 1'b1); chk(n_take, t);
      nmi_pin_n <= 1'b1; rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk) chk(core_halt, 1'b0);
      nmi_pin_n <= 1'b0; tk(SRC_NMI); nmi_pin_n <= 1'b1;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      s_reg;
      s_tmr;
      s_edge;
      s_wait;
      s_stop;
      s_gen0;
      repeat (5) @(posedge ref_clk);
      stop_test;
   end
endmodule
